// ==== srcp_port.sv ====
// Serial register control port: device-side slave for a host serial master.
// Assumes the serial clock runs at most near three fifths of CLK_SYS so that the
// oversampled edges are seen; the register file proper lies outside.

`timescale 1ns/1ps

// Behaviour
// - Eight rising serial edges shift in the instruction, then the data phase follows.
// - Instruction MSB high means read, low means write.
// - Byte-count bits 00,01,10,11 give one to four data bytes.
// - Low five bits give start address; later addresses are generated here.
// - Each written byte updates its register at its last bit.
// - Input sampled on rising serial edges; read data changes on falling edges.
// - Select high tristates both data outputs; select low starts a cycle.
// - Control bit 7 makes the data input pin drive read data instead of the separate output pin.
// - In three-wire mode the separate output pin stays tristated.
// - Control bit 6 picks LSB-first order; reset gives MSB-first.
// - MSB-first decrements the address per byte, wrapping 0x00 to 0x1F.
// - LSB-first increments the address per byte, wrapping 0x1F to 0x00.
// - New port settings apply from the next byte of the same cycle.
// - Soft reset bit resets all other registers, not the control register.
// - A mirrored pattern write to 0x00 recovers configuration in either order.
// - The next write to 0x00, if mirrored with reset low, reloads the oscillator multiplier.
module srcp_port
	import srcp_pkg::*;
(
	input wire logic CLK_SYS,
	input wire logic RST_N,
	input wire logic SCLK,
	input wire logic CS_N,
	input wire logic SDIO_I,
	output logic SDIO_O,
	output logic SDIO_OE,
	output logic SDO_O,
	output logic SDO_OE,
	output logic [srcp_pkg::ADDR_W-1:0] RD_ADDR,
	input wire logic [srcp_pkg::BYTE_W-1:0] RD_DATA,
	output logic WR_STROBE,
	output logic [srcp_pkg::ADDR_W-1:0] WR_ADDR,
	output logic [srcp_pkg::BYTE_W-1:0] WR_DATA,
	output logic [srcp_pkg::BYTE_W-1:0] CTRL_REG,
	output logic SOFT_RESET,
	output logic OSC_MULT_LOAD
);
	import srcp_pkg::*;

	// ----------------------------------------------------------------
	// Pin synchronisation and edge detection
	// ----------------------------------------------------------------
	logic sclk_s;
	logic cs_n_s;
	logic sdi_s;
	logic sclk_prev_q;
	logic cs_act;
	logic rise;
	logic fall;

	// Synchronisers reset to the idle pin levels, so no cycle seems to start after reset.
	srcp_sync #(.WIDTH(3), .IDLE(PIN_IDLE)) u_sync (
		.clk(CLK_SYS),
		.rst_n(RST_N),
		.async_in({SCLK, CS_N, SDIO_I}),
		.sync_out({sclk_s, cs_n_s, sdi_s})
	);

	// Previous serial clock level, used only to find its edges.
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			sclk_prev_q <= 1'b1;
		end else begin
			sclk_prev_q <= sclk_s;
		end
	end

	// Edges count only while select is low, so stray clocks are ignored.
	assign cs_act = ~cs_n_s;
	assign rise = cs_act & sclk_s & ~sclk_prev_q;
	assign fall = cs_act & ~sclk_s & sclk_prev_q;

	// ----------------------------------------------------------------
	// Shift-in path and byte decode
	// ----------------------------------------------------------------
	srcp_state_t state_q;
	logic [2:0] bit_cnt_q;
	logic [7:0] sh_q;
	logic [7:0] byte_in;
	logic byte_done;
	logic rw_q;
	logic [1:0] bytes_left_q;
	logic [ADDR_W-1:0] addr_q;
	logic [7:0] ctrl_q;
	logic [7:0] ctrl_d;
	logic lsb_first;
	logic ctrl_wr;
	logic other_wr;
	logic mirrored;
	logic recover_q;

	assign lsb_first = ctrl_q[CFG_LSB_FIRST_BIT];

	assign byte_in = lsb_first ? {sdi_s, sh_q[7:1]} : {sh_q[6:0], sdi_s};
	assign byte_done = rise && (bit_cnt_q == LAST_BIT);

	// Shift register and bit counter; a high select clears the count.
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			sh_q <= 8'h00;
			bit_cnt_q <= 3'h0;
		end else if (!cs_act) begin
			bit_cnt_q <= 3'h0;
		end else if (rise) begin
			sh_q <= byte_in;
			bit_cnt_q <= bit_cnt_q + 3'h1;
		end
	end

	// Write decode for the completed byte of a write data phase.
	assign ctrl_wr = byte_done && (state_q == SRCP_DATA) && !rw_q && (addr_q == CTRL_REG_ADDR);
	assign other_wr = byte_done && (state_q == SRCP_DATA) && !rw_q && (addr_q != CTRL_REG_ADDR);
	assign ctrl_d = ctrl_wr ? byte_in : ctrl_q;
	// mirror test, symmetric so it reads alike in either bit order
	assign mirrored = (byte_in[0] == byte_in[7]) && (byte_in[1] == byte_in[6]);

	// ----------------------------------------------------------------
	// Cycle sequencer
	// ----------------------------------------------------------------
	// abort on select high
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			state_q <= SRCP_IDLE;
			rw_q <= 1'b0;
			bytes_left_q <= 2'h0;
			addr_q <= 5'h00;
		end else if (!cs_act) begin
			state_q <= SRCP_IDLE;
		end else begin
			unique case (state_q)
				SRCP_IDLE: begin
					state_q <= SRCP_INSTR;
				end
				SRCP_INSTR: begin
					if (byte_done) begin
						state_q <= SRCP_DATA;
						rw_q <= byte_in[7];
						bytes_left_q <= byte_in[6:5];
						addr_q <= byte_in[4:0];
					end
				end
				SRCP_DATA: begin
					if (byte_done) begin
						if (bytes_left_q == 2'h0) begin
							state_q <= SRCP_DONE;
						end else begin
							bytes_left_q <= bytes_left_q - 2'h1;
							// decrement, increment; both wrap by width
							if (ctrl_d[CFG_LSB_FIRST_BIT]) begin
								addr_q <= addr_q + 5'h01;
							end else begin
								addr_q <= addr_q - 5'h01;
							end
						end
					end
				end
				SRCP_DONE: begin
					state_q <= SRCP_DONE; // Extra clocks are ignored until select rises.
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Control register and its side effects
	// ----------------------------------------------------------------
	// control byte, applied at its last bit
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			ctrl_q <= CTRL_REG_RESET;
		end else begin
			ctrl_q <= ctrl_d;
		end
	end

	// soft reset pulse, which leaves the control byte alone
	// multiplier reload after a recovery write
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			SOFT_RESET <= 1'b0;
			OSC_MULT_LOAD <= 1'b0;
			recover_q <= 1'b0;
		end else begin
			SOFT_RESET <= ctrl_wr && byte_in[SOFT_RESET_BIT];
			OSC_MULT_LOAD <= ctrl_wr && recover_q && mirrored && !byte_in[SOFT_RESET_BIT];
			if (ctrl_wr) begin
				recover_q <= mirrored && (byte_in[5:2] == RECOVER_CORE);
			end
		end
	end

	assign CTRL_REG = ctrl_q;

	// ----------------------------------------------------------------
	// Write strobe towards the outer register file
	// ----------------------------------------------------------------
	// per-byte update
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			WR_STROBE <= 1'b0;
			WR_ADDR <= 5'h00;
			WR_DATA <= 8'h00;
		end else begin
			WR_STROBE <= other_wr;
			if (other_wr) begin
				WR_ADDR <= addr_q;
				WR_DATA <= byte_in;
			end
		end
	end

	assign RD_ADDR = addr_q;

	// ----------------------------------------------------------------
	// Read data path
	// ----------------------------------------------------------------
	logic [7:0] tx_q;
	logic [7:0] rd_src;
	logic dout_q;
	logic drv_q;
	logic sdio_oe_q;
	logic sdo_oe_q;

	// The control byte is held here, so its reads never leave the port.
	assign rd_src = (addr_q == CTRL_REG_ADDR) ? ctrl_q : RD_DATA;

	// read data changes on falling edges; the first bit of each byte loads fresh.
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			tx_q <= 8'h00;
			dout_q <= 1'b0;
			drv_q <= 1'b0;
		end else if (!cs_act) begin
			drv_q <= 1'b0;
		end else if (fall && (state_q == SRCP_DATA) && rw_q) begin
			drv_q <= 1'b1;
			if (bit_cnt_q == 3'h0) begin
				dout_q <= lsb_first ? rd_src[0] : rd_src[7];
				tx_q <= lsb_first ? {1'b0, rd_src[7:1]} : {rd_src[6:0], 1'b0};
			end else begin
				dout_q <= lsb_first ? tx_q[0] : tx_q[7];
				tx_q <= lsb_first ? {1'b0, tx_q[7:1]} : {tx_q[6:0], 1'b0};
			end
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			sdio_oe_q <= 1'b0;
			sdo_oe_q <= 1'b0;
		end else begin
			sdio_oe_q <= cs_act && drv_q && ctrl_q[CFG_BIDIR_BIT];
			sdo_oe_q <= cs_act && drv_q && !ctrl_q[CFG_BIDIR_BIT];
		end
	end

	assign SDIO_O = dout_q;
	assign SDO_O = dout_q;
	assign SDIO_OE = sdio_oe_q;
	assign SDO_OE = sdo_oe_q;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (!RST_N);

	sequence s_instr_taken;
		(state_q == SRCP_INSTR) && byte_done;
	endsequence

	sequence s_data_more;
		(state_q == SRCP_DATA) && byte_done && (bytes_left_q != 2'h0);
	endsequence

	chk_tristate_idle: assert property (!cs_act |=> !SDIO_OE && !SDO_OE)
		else $error("Data pins driven while deselected.");

	chk_bidir_quiet_sdo: assert property (ctrl_q[CFG_BIDIR_BIT] |=> !SDO_OE)
		else $error("Output pin driven in three-wire mode.");

	chk_instr_decode: assert property (s_instr_taken |=> (state_q == SRCP_DATA || !cs_act)
		&& rw_q == $past(byte_in[7]) && bytes_left_q == $past(byte_in[6:5]))
		else $error("Instruction fields not captured.");

	chk_start_addr: assert property (s_instr_taken |=> addr_q == $past(byte_in[4:0]))
		else $error("Start address not captured.");

	chk_addr_dec: assert property (s_data_more ##0 (!ctrl_d[CFG_LSB_FIRST_BIT] && cs_act)
		|=> addr_q == $past(addr_q) - 5'h01)
		else $error("Address did not decrement.");

	chk_addr_inc_wrap: assert property (s_data_more ##0 (ctrl_d[CFG_LSB_FIRST_BIT] && addr_q == ADDR_LAST)
		|=> addr_q == 5'h00)
		else $error("Address did not wrap upward.");

	chk_last_byte_done: assert property ((state_q == SRCP_DATA) && byte_done
		&& bytes_left_q == 2'h0 && cs_act |=> state_q == SRCP_DONE)
		else $error("Cycle did not end after its byte count.");

	chk_write_strobe: assert property (other_wr |=> WR_STROBE && WR_DATA == $past(byte_in) ##1 !WR_STROBE)
		else $error("Write strobe wrong.");

	chk_soft_reset: assert property (ctrl_wr && byte_in[SOFT_RESET_BIT]
		|=> SOFT_RESET && CTRL_REG == $past(byte_in))
		else $error("Soft reset pulse missing.");

	chk_bidir_drive: assert property (SDIO_OE |-> CTRL_REG[CFG_BIDIR_BIT] && rw_q)
		else $error("Shared pin driven outside a three-wire read.");

	chk_osc_reload: assert property (OSC_MULT_LOAD |-> !SOFT_RESET && !CTRL_REG[SOFT_RESET_BIT]
		&& CTRL_REG[0] == CTRL_REG[7] && CTRL_REG[1] == CTRL_REG[6])
		else $error("Multiplier reload without a mirrored write.");

	chk_cs_abort: assert property ($rose(cs_n_s) |=> state_q == SRCP_IDLE && bit_cnt_q == 3'h0)
		else $error("Select high did not abort the cycle.");

	chk_instr_eight: assert property ((state_q == SRCP_INSTR) && rise && bit_cnt_q != LAST_BIT
		|=> state_q != SRCP_DATA)
		else $error("Data phase began before eight bits.");
endmodule : srcp_port

// ==== srcp_sync.sv ====
// Package of constants for the serial register control port, and the
// two-flop synchroniser that brings its pins into the system clock domain.
// Assumes a single system clock; every pin is asynchronous to it.

package srcp_pkg;
	// ----------------------------------------------------------------
	// Widths, register 0x00 layout and timing figures
	// ----------------------------------------------------------------
	localparam int ADDR_W = 5;
	localparam int BYTE_W = 8;
	localparam logic [4:0] CTRL_REG_ADDR = 5'h00;
	localparam logic [4:0] ADDR_LAST = 5'h1f;
	localparam logic [7:0] CTRL_REG_RESET = 8'h00;
	localparam int CFG_BIDIR_BIT = 7;
	localparam int CFG_LSB_FIRST_BIT = 6;
	localparam int SOFT_RESET_BIT = 5;
	localparam logic [3:0] RECOVER_CORE = 4'h9; // Bits 5..2 of a recovery write.
	localparam logic [2:0] LAST_BIT = 3'h7;
	localparam int SYNC_STAGES = 2;
	// Idle pin levels {SCLK, CS_N, SDIO_I}: clock high, deselected, data low.
	localparam logic [2:0] PIN_IDLE = 3'h6;
	localparam int SCLK_MAX_KHZ = 15000;
	localparam int SYS_CLK_KHZ = 25000;
	localparam int WAKE_MCLK_CYCLES = 200;
	// System cycles in the shortest serial clock period, rounded down.
	localparam int SCLK_MIN_PERIOD_CYC = (SYS_CLK_KHZ / SCLK_MAX_KHZ) > 0 ? (SYS_CLK_KHZ / SCLK_MAX_KHZ) : 1;

	// Port sequencer states, Gray coded along idle, instruction, data, done.
	typedef enum logic [1:0] {
		SRCP_IDLE = 2'h0,
		SRCP_INSTR = 2'h1,
		SRCP_DATA = 2'h3,
		SRCP_DONE = 2'h2
	} srcp_state_t;
endpackage : srcp_pkg

`timescale 1ns/1ps

module srcp_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] IDLE = '0
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_q;

	// Two flops; the first is read only by the second to keep metastability contained.
	// Reset loads the idle levels, so leaving reset shows no false edge or select.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			meta_q <= IDLE;
			sync_out <= IDLE;
		end else begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule : srcp_sync

// ==== srcp_host.sv ====
// Host serial master model that drives the register control port pins.
// Assumes the bench calls its tasks from a falling system clock edge and
// resolves the shared data line into the sdio input.
`timescale 1ns/1ps

module srcp_host (
	input wire logic clk,
	input wire logic sdio,
	input wire logic serial_read_out,
	output logic sclk,
	output logic cs_n,
	output logic sdi
);
	logic lsb = 1'b0;
	logic bidir = 1'b0;
	logic rd_mode = 1'b0;

	// ----------------------------------------------------------------
	// Pin idle levels
	// ----------------------------------------------------------------
	// The serial clock stands high between frames.
	initial begin
		sclk = 1'b1;
		cs_n = 1'b1;
		sdi = 1'b0;
	end

	task automatic start();
		cs_n = 1'b0;
		repeat (4) @(negedge clk);
	endtask : start

	// shift the first nb bits of one byte.
	// Each clock level lasts four system cycles, so the port sees every edge.
	// While reading, the data pin toggles so a stale level cannot pass.
	task automatic shift(input logic [7:0] tx, input int nb, output logic [7:0] rx);
		int k;
		rx = 8'h00;
		for (int i = 0; i < nb; i++) begin
			k = lsb ? i : 7 - i;
			sclk = 1'b0;
			sdi = rd_mode ? ~sdi : tx[k];
			repeat (4) @(negedge clk);
			rx[k] = bidir ? sdio : serial_read_out;
			sclk = 1'b1;
			repeat (4) @(negedge clk);
		end
	endtask : shift

	// Select stays high long enough for the pins to be released.
	task automatic stop();
		cs_n = 1'b1;
		repeat (6) @(negedge clk);
	endtask : stop
endmodule : srcp_host

// ==== tb.sv ====
// Self-checking bench for the serial register control port.
// Assumes srcp_pkg and srcp_port are compiled first; the host model drives pins.
`timescale 1ns/1ps

module tb;
	import srcp_pkg::*;
	logic CLK_SYS = 1'b0;
	logic RST_N = 1'b0;
	logic [7:0] RD_DATA = 8'h00;
	logic SCLK, CS_N, sdi, SDIO_O, SDIO_OE, SDO_O, SDO_OE, WR_STROBE, SOFT_RESET, OSC_MULT_LOAD;
	logic [4:0] RD_ADDR, WR_ADDR;
	logic [7:0] WR_DATA, CTRL_REG;
	logic [7:0] cfg = 8'h00;
	logic [12:0] wq[$];
	int errors = 0;
	int n_checks = 0;
	int n_soft = 0;
	int n_osc = 0;
	int cs_hi = 0;
	int cyc = 0;
	wire line = SDIO_OE ? SDIO_O : sdi;
	// A released output pin shows the inverse of its data, so a missing enable is caught.
	wire sdo_line = SDO_OE ? SDO_O : ~SDO_O;

	always #20 CLK_SYS = ~CLK_SYS;

	srcp_port DUT (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .SCLK(SCLK), .CS_N(CS_N), .SDIO_I(line),
		.SDIO_O(SDIO_O), .SDIO_OE(SDIO_OE), .SDO_O(SDO_O), .SDO_OE(SDO_OE), .RD_ADDR(RD_ADDR),
		.RD_DATA(RD_DATA), .WR_STROBE(WR_STROBE), .WR_ADDR(WR_ADDR), .WR_DATA(WR_DATA),
		.CTRL_REG(CTRL_REG), .SOFT_RESET(SOFT_RESET), .OSC_MULT_LOAD(OSC_MULT_LOAD));
	srcp_host host (.clk(CLK_SYS), .sdio(line), .serial_read_out(sdo_line), .sclk(SCLK), .cs_n(CS_N), .sdi(sdi));

	// Outer register file stand-in: a fixed pattern per address.
	function automatic logic [7:0] reg_val(input logic [4:0] a);
		return {a, a[2:0]} ^ 8'h5a;
	endfunction : reg_val

	always @(negedge CLK_SYS) RD_DATA <= reg_val(RD_ADDR);

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic complete_run();
		if (errors == 0 && n_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : complete_run

	// Pulse capture, pin release and the hang limit.
	always @(posedge CLK_SYS) begin
		if (WR_STROBE === 1'b1) wq.push_back({WR_ADDR, WR_DATA});
		if (SOFT_RESET === 1'b1) n_soft++;
		if (OSC_MULT_LOAD === 1'b1) n_osc++;
		cs_hi <= CS_N ? cs_hi + 1 : 0;
		cyc <= cyc + 1;
		if (RST_N && cs_hi > 5) check("idle enables", {SDIO_OE, SDO_OE}, 2'b00);
		if (RST_N) check("pin choice", {SDIO_OE & ~CTRL_REG[7], SDO_OE & CTRL_REG[7]}, 2'b00);
		if (cyc > 60000) begin
			errors++;
			complete_run();
		end
	end

	// one framed transfer.
	// The next address follows the bit order in force after each byte.
	task automatic frame(input logic rd, input logic [4:0] a0, input int n, input logic [31:0] wd);
		logic [7:0] rx;
		logic [7:0] b;
		logic [4:0] a;
		logic [12:0] eq[$];
		a = a0;
		wq.delete();
		host.rd_mode = 1'b0;
		host.start();
		host.shift({rd, 2'(n - 1), a0}, 8, rx);
		host.rd_mode = rd;
		for (int i = 0; i < n; i++) begin
			b = wd[8*i +: 8];
			host.shift(b, 8, rx);
			if (rd) check("read byte", rx, (a == 5'h00) ? cfg : reg_val(a));
			else if (a == 5'h00) begin
				cfg = b;
				host.lsb = b[6];
				host.bidir = b[7];
			end else eq.push_back({a, b});
			a = host.lsb ? a + 5'h01 : a - 5'h01;
		end
		host.stop();
		check("strobe count", wq.size(), eq.size());
		for (int i = 0; i < eq.size(); i++) check("write", (i < wq.size()) ? wq[i] : 13'h1fff, eq[i]);
	endtask : frame

	initial begin
		logic [7:0] rx;
		logic r;
		void'($urandom(44));
		repeat (10) @(negedge CLK_SYS);
		RST_N = 1'b1;
		@(negedge CLK_SYS);
		check("reset", {CTRL_REG, WR_STROBE, SOFT_RESET, OSC_MULT_LOAD, SDO_OE, SDIO_OE}, 13'h0);
		// random traffic in each order, wrap corners after.
		for (int m = 0; m < 2; m++) begin
			for (int i = 0; i < 7; i++) begin
				r = 1'($urandom_range(1));
				frame(r, r ? 5'($urandom_range(31)) : 5'($urandom_range(27, 4)), $urandom_range(4, 1), $urandom);
			end
			frame(1'b1, m ? 5'h1e : 5'h01, 4, 0);
			if (m == 0) frame(1'b0, 5'h00, 2, 32'h3c40);
			check("control", CTRL_REG, cfg);
		end
		// single-byte recovery written in the other order.
		n_soft = 0;
		frame(1'b0, 5'h00, 1, 32'h24);
		check("soft reset", n_soft, 1);
		check("order back", CTRL_REG[7:6], 2'b00);
		n_osc = 0;
		frame(1'b0, 5'h00, 1, 32'h00);
		check("mult load", n_osc, 1);
		// wake-up wait before relying on the new clock.
		repeat (WAKE_MCLK_CYCLES) @(negedge CLK_SYS);
		// abort in each phase loses the partial byte.
		wq.delete();
		host.start();
		host.shift(8'h0f, 4, rx);
		host.stop();
		host.start();
		host.shift(8'h0a, 8, rx);
		host.shift(8'hff, 5, rx);
		host.stop();
		check("abort", wq.size(), 0);
		frame(1'b0, 5'h0b, 1, 32'h96);
		// three-wire reads on the shared pin.
		frame(1'b0, 5'h00, 1, 32'h80);
		frame(1'b1, 5'h00, 1, 0);
		frame(1'b1, 5'h07, 3, 0);
		complete_run();
	end
endmodule : tb
